/* pkg/sdsi_pkg.sv */
// Package for the step/direction setpoint input block
package sdsi_pkg;

    // ****************************************************************
    // Modes and timing
    // ****************************************************************
    // Step interpretation modes
    typedef enum logic
    {
        SDSI_MODE_STEP_DIR,                 // Step line plus rotation sense
        SDSI_MODE_FWD_BWD                   // Separate forward / backward lines
    } sdsi_mode_type;

    // Status output meaning
    typedef enum logic
    {
        SDSI_STAT_ERROR,                    // Report fault condition
        SDSI_STAT_MOVING                    // Report speed not zero
    } sdsi_stat_type;

    // Clock period in picoseconds (125 MHz)
    localparam int unsigned SDSI_CLK_PERIOD_PS = 8000;
    // Longest time from enable to ready, in ms
    localparam int unsigned SDSI_READY_MAX_MS  = 100;
    // Ready delay in cycles, longest time rounds down
    localparam int unsigned SDSI_READY_CYCLES  =
        (SDSI_READY_MAX_MS * 1000 * 1000) / (SDSI_CLK_PERIOD_PS / 1000);
    // Default settle time before ready, in cycles
    localparam int unsigned SDSI_SETTLE_DEF    = 32'h0000_0400;
    // Reset value of the position count
    localparam logic [31:0] SDSI_POS_RESET     = 32'h0000_0000;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    // Synchronised line levels
    typedef struct packed
    {
        logic step_or_forward_line;         // Step or forward line
        logic rotation_sense_or_backward_line; // Sense or backward line
        logic enable_line;                  // Amplifier enable line
    } sdsi_lines_type;

    // One step event with its direction
    typedef struct packed
    {
        logic valid;                        // One step this cycle
        logic ccw;                          // High means counterclockwise
    } sdsi_step_type;

endpackage

/* hw/sdsi_top.sv */
// Step/direction setpoint input with enable, ready and status outputs
//
// Contract
// - Mode setting picks step-dir or forward-backward
// - Step-dir: rising step edge makes one step
// - Direction low clockwise, high counterclockwise
// - Forward rise clockwise, backward rise counterclockwise
// - Enable low disables, high enables amplifier
// - Ready goes low within 100 ms
// - Ready high when disabled, low when enabled; code also holds it high while i_fault is high
// - Inverted ready copy on separate output
// - Setting selects error or moving status
// - Status high when selected condition present
// - Inverted status copy also provided
`timescale 1ns/1ps
`default_nettype none

module sdsi_top
    import sdsi_pkg::*;
#(
    parameter int unsigned READY_DELAY = SDSI_SETTLE_DEF  // Enable-to-ready cycles
)
(
    // Clock, reset, enable
    input  wire logic          i_clk_sys,
    input  wire logic          i_arst_n,
    input  wire logic          i_ce,
    // Step interface lines
    input  wire logic          i_step_or_forward_line,
    input  wire logic          i_rotation_sense_or_backward_line,
    input  wire logic          i_enable_line,
    // Configuration
    input  wire sdsi_mode_type i_step_mode_setting,
    input  wire sdsi_stat_type i_status_meaning_setting,
    input  wire logic          i_fault,
    input  wire logic          i_speed_nonzero,
    // Step outputs to position loop
    output logic               o_step_valid,
    output logic               o_step_ccw,
    output logic [31:0]        o_position,
    // Amplifier and status
    output logic               o_amp_enable,
    output logic               o_ready_n,
    output logic               o_drive_ready_copy,
    output logic               o_status_flag_out,
    output logic               o_status_flag_out_n
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    sdsi_lines_type meta_r;                 // First stage, read only by sync_r
    sdsi_lines_type sync_r;                 // Second stage
    sdsi_lines_type prev_r;                 // Delayed copy for edges
    sdsi_lines_type sync_nxt;
    sdsi_lines_type prev_nxt;
    sdsi_lines_type meta_nxt;

    // Lines arrive unrelated to our clock, so two flops come first
    // Only the second stage and its delayed copy feed the edge logic, never the first
    // Next values of the synchroniser chain
    always_comb
    begin
        meta_nxt = '{i_step_or_forward_line, i_rotation_sense_or_backward_line,
                     i_enable_line};
        sync_nxt = meta_r;
        prev_nxt = sync_r;
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end
        else if (i_ce)
        begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            prev_r <= prev_nxt;
        end
    end

    // ****************************************************************
    // Step decoding
    // ****************************************************************
    logic          rise_a;                  // Rising edge on first line
    logic          rise_b;                  // Rising edge on second line
    sdsi_step_type step_nxt;
    sdsi_step_type step_r;
    logic [31:0]   pos_r;
    logic [31:0]   pos_nxt;

    // Edge detect and mode decode
    always_comb
    begin
        rise_a   = sync_r.step_or_forward_line & ~prev_r.step_or_forward_line;
        rise_b   = sync_r.rotation_sense_or_backward_line
                   & ~prev_r.rotation_sense_or_backward_line;
        step_nxt = '0;
        pos_nxt  = pos_r;
        case (i_step_mode_setting)
            SDSI_MODE_STEP_DIR:
            begin
                step_nxt.valid = rise_a;
                step_nxt.ccw   = sync_r.rotation_sense_or_backward_line;
            end
            SDSI_MODE_FWD_BWD:
            begin
                // forward cw, backward ccw; both cancel
                step_nxt.valid = rise_a ^ rise_b;
                step_nxt.ccw   = rise_b;
            end
            default:
            begin
                step_nxt = '0;
            end
        endcase
        // Steps during disable are dropped, never queued
        // Only count steps while the amplifier is on
        if (step_nxt.valid && o_amp_enable)
        begin
            pos_nxt = step_nxt.ccw ? pos_r - 32'h0000_0001 : pos_r + 32'h0000_0001;
        end
        else
        begin
            step_nxt.valid = 1'b0;
        end
    end

    // Register step event and position
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            step_r <= '0;
            pos_r  <= SDSI_POS_RESET;
        end
        else if (i_ce)
        begin
            step_r <= step_nxt;
            pos_r  <= pos_nxt;
        end
    end

    // ****************************************************************
    // Enable and ready
    // ****************************************************************
    logic [31:0] rdy_cnt_r;                 // Settle counter after enable
    logic [31:0] rdy_cnt_nxt;
    logic        ready_r;                   // Drive ready, active high
    logic        ready_nxt;

    assign o_amp_enable = sync_r.enable_line;

    // Settle counter and ready flag
    // Fault or loss of enable restarts the settle count
    // Counter stops at the limit, so it never wraps
    always_comb
    begin
        rdy_cnt_nxt = rdy_cnt_r;
        ready_nxt   = 1'b0;
        if (!sync_r.enable_line || i_fault)
        begin
            rdy_cnt_nxt = '0;
        end
        else if (rdy_cnt_r >= READY_DELAY)
        begin
            ready_nxt = 1'b1;
        end
        else
        begin
            rdy_cnt_nxt = rdy_cnt_r + 32'h0000_0001;
        end
    end

    // Register ready state
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rdy_cnt_r <= '0;
            ready_r   <= 1'b0;
        end
        else if (i_ce)
        begin
            rdy_cnt_r <= rdy_cnt_nxt;
            ready_r   <= ready_nxt;
        end
    end

    // ****************************************************************
    // Status output
    // ****************************************************************
    logic stat_r;
    logic stat_nxt;

    always_comb
    begin
        case (i_status_meaning_setting)
            SDSI_STAT_ERROR:  stat_nxt = i_fault;
            SDSI_STAT_MOVING: stat_nxt = i_speed_nonzero;
            default:          stat_nxt = i_fault;
        endcase
    end

    // Register status, one cycle behind the selected condition
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            stat_r <= 1'b0;
        else if (i_ce)
            stat_r <= stat_nxt;
    end

    // Output drive
    assign o_step_valid        = step_r.valid;
    assign o_step_ccw          = step_r.ccw;
    assign o_position          = pos_r;
    assign o_ready_n           = ~ready_r;
    assign o_drive_ready_copy  = ready_r;
    assign o_status_flag_out   = stat_r;
    assign o_status_flag_out_n = ~stat_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    localparam int unsigned READY_LIMIT_CHK = 1000;
    // Checks on state only count cycles with the clock enable high

    a_step_dir_rise: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_ce && i_step_mode_setting == SDSI_MODE_STEP_DIR && o_amp_enable
         && sync_r.step_or_forward_line && !prev_r.step_or_forward_line)
        |=> o_step_valid)
        else $error("step edge did not give a step");

    a_step_dir_sense: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_ce && i_step_mode_setting == SDSI_MODE_STEP_DIR && step_nxt.valid)
        |=> o_step_ccw == $past(sync_r.rotation_sense_or_backward_line))
        else $error("step direction wrong");

    a_fwd_bwd_dir: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_ce && i_step_mode_setting == SDSI_MODE_FWD_BWD && o_amp_enable
         && sync_r.rotation_sense_or_backward_line
         && !prev_r.rotation_sense_or_backward_line
         && !(sync_r.step_or_forward_line && !prev_r.step_or_forward_line))
        |=> o_step_valid && o_step_ccw)
        else $error("backward edge not ccw step");

    a_pos_count: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_ce && step_nxt.valid) |=> o_position != $past(o_position))
        else $error("position did not move on step");

    a_amp_disable: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_ce && !i_enable_line) ##1 i_ce
        |=> !o_amp_enable)
        else $error("amplifier on while disabled");

    a_ready_off: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_ce && !o_amp_enable) |=> o_ready_n)
        else $error("ready low while disabled");

    a_ready_bound: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (READY_DELAY < READY_LIMIT_CHK && i_ce && $rose(o_amp_enable) && !i_fault)
        ##1 (i_ce && o_amp_enable && !i_fault) [*8]
        |-> (rdy_cnt_r != 32'h0000_0000))
        else $error("ready counter not advancing");

    a_ready_copy: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        o_drive_ready_copy != o_ready_n)
        else $error("ready copy not inverted");

    a_status_sel: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_ce && i_status_meaning_setting == SDSI_STAT_MOVING)
        |=> o_status_flag_out == $past(i_speed_nonzero))
        else $error("status not following speed");

    a_status_error: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_ce && i_status_meaning_setting == SDSI_STAT_ERROR)
        |=> o_status_flag_out == $past(i_fault))
        else $error("status not following fault");

    a_status_inv: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        o_status_flag_out_n == !o_status_flag_out)
        else $error("status copy not inverted");

endmodule

`default_nettype wire

/* bench/sdsi_ctrl_model.sv */
// Motion controller model driving step, sense and enable lines
`timescale 1ns/1ps
`default_nettype none

module sdsi_ctrl_model
    import sdsi_pkg::*;
#(
    parameter int unsigned HALF = 1300      // Cycles per line level
)
(
    // Clock
    input  wire logic         i_clk_sys,
    // Lines to the drive
    output var sdsi_lines_type o_lines
);
    // ******
    // Line tasks
    // ******
    // All lines idle low from time zero
    initial o_lines = '0;

    task automatic hold();
        repeat (HALF) @(negedge i_clk_sys);
    endtask

    // Enable level, changed after a falling edge
    task automatic set_enable(input logic lvl);
        @(negedge i_clk_sys);
        o_lines.enable_line = lvl;
    endtask

    task automatic set_sense(input logic lvl);
        @(negedge i_clk_sys);
        o_lines.rotation_sense_or_backward_line = lvl;
        hold();
    endtask

    // One pulse on the chosen lines
    task automatic pulse(input logic [1:0] which);
        @(negedge i_clk_sys);
        if (which[0])
            o_lines.step_or_forward_line = 1'b1;
        if (which[1])
            o_lines.rotation_sense_or_backward_line = 1'b1;
        hold();
        if (which[0])
            o_lines.step_or_forward_line = 1'b0;
        if (which[1])
            o_lines.rotation_sense_or_backward_line = 1'b0;
        hold();
    endtask
endmodule

`default_nettype wire

/* bench/tb_top.sv */
// Self-checking testbench for the step/direction setpoint input
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import sdsi_pkg::*;
    // ******
    // Signals
    // ******
    localparam int unsigned DLY = 8;            // Short ready delay
    logic           clk_sys  = 1'b0;             // System clock
    logic           arst_n   = 1'b0;             // Reset, active low
    logic           ce       = 1'b1;             // Clock enable
    sdsi_mode_type  mode     = SDSI_MODE_STEP_DIR; // Step mode
    sdsi_stat_type  meaning  = SDSI_STAT_ERROR;  // Status meaning
    logic           fault    = 1'b0;             // Fault input
    logic           speed    = 1'b0;             // Speed input
    sdsi_lines_type lines;                       // Controller lines
    logic           step_valid, step_ccw, amp_en, ready_n, ready_copy, stat, stat_n;
    logic [31:0]    position;                    // Step count
    logic [31:0]    pos_exp  = SDSI_POS_RESET;   // Expected count
    logic           exp_q[$];                    // Expected step senses
    logic           e, w;                        // Scratch bits
    int             fails    = 0;                // Mismatch count
    int             checks   = 0;                // Comparison count
    int             seed     = 96402;            // Random seed

    // Clock at 125 MHz
    always #4 clk_sys = ~clk_sys;

    // Controller model and design
    sdsi_ctrl_model #(.HALF(1300)) i_sdsi_ctrl_model (.i_clk_sys(clk_sys), .o_lines(lines));
    sdsi_top #(.READY_DELAY(DLY)) i_sdsi_top (
        .i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_ce(ce),
        .i_step_or_forward_line(lines.step_or_forward_line),
        .i_rotation_sense_or_backward_line(lines.rotation_sense_or_backward_line),
        .i_enable_line(lines.enable_line), .i_step_mode_setting(mode),
        .i_status_meaning_setting(meaning), .i_fault(fault), .i_speed_nonzero(speed),
        .o_step_valid(step_valid), .o_step_ccw(step_ccw), .o_position(position),
        .o_amp_enable(amp_en), .o_ready_n(ready_n), .o_drive_ready_copy(ready_copy),
        .o_status_flag_out(stat), .o_status_flag_out_n(stat_n));

    // ******
    // Compare and closing tasks
    // ******
    // Single bit result
    task automatic cmp_bit(input string name, input logic exp, input logic seen);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %b seen %b", name, exp, seen);
        end
    endtask

    // Position result
    task automatic cmp_pos(input logic [31:0] exp, input logic [31:0] seen);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected position: expected %h seen %h", exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic test_done();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Bounded wait for a ready level, then compare both copies
    task automatic wait_ready(input logic lvl);
        for (int n = 0; n < DLY + 8 && ready_n !== lvl; n++)
            @(negedge clk_sys);
        cmp_bit("ready_n", lvl, ready_n);
        cmp_bit("ready_copy", ~lvl, ready_copy);
    endtask

    // ******
    // Step monitor
    // ******
    // Each pulse takes the oldest note; a pulse with none is a mismatch
    always @(negedge clk_sys)
    begin
        if (step_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                cmp_bit("step_valid", 1'b0, 1'b1);
            else
            begin
                e = exp_q.pop_front();
                pos_exp = e ? pos_exp - 32'h0000_0001 : pos_exp + 32'h0000_0001;
                cmp_bit("step_ccw", e, step_ccw);
                cmp_pos(pos_exp, position);
            end
        end
    end

    // Watchdog well past the expected run length
    initial
    begin
        repeat (90000) @(posedge clk_sys);
        fails++;
        test_done();
    end

    // ******
    // Main sequence
    // ******
    initial
    begin
        repeat (16) @(negedge clk_sys);
        arst_n = 1'b1;
        @(negedge clk_sys);
        cmp_bit("ready_n", 1'b1, ready_n);
        i_sdsi_ctrl_model.set_enable(1'b1);
        wait_ready(1'b0);
        cmp_bit("amp_enable", 1'b1, amp_en);
        $display("test ready done");
        // Random senses, step line only
        for (int i = 0; i < 8; i++)
        begin
            w = 1'($random(seed));
            i_sdsi_ctrl_model.set_sense(w);
            exp_q.push_back(w);
            i_sdsi_ctrl_model.pulse(2'b01);
        end
        i_sdsi_ctrl_model.set_sense(1'b0);
        $display("test step_dir done");
        mode = SDSI_MODE_FWD_BWD;
        for (int i = 0; i < 8; i++)
        begin
            w = 1'($random(seed));
            exp_q.push_back(w);
            i_sdsi_ctrl_model.pulse(w ? 2'b10 : 2'b01);
        end
        // Both lines at once give no step
        i_sdsi_ctrl_model.pulse(2'b11);
        $display("test fwd_bwd done");
        i_sdsi_ctrl_model.set_enable(1'b0);
        repeat (4) @(negedge clk_sys);
        cmp_bit("amp_enable", 1'b0, amp_en);
        wait_ready(1'b1);
        i_sdsi_ctrl_model.pulse(2'b01);
        i_sdsi_ctrl_model.set_enable(1'b1);
        wait_ready(1'b0);
        fault = 1'b1;
        wait_ready(1'b1);
        fault = 1'b0;
        wait_ready(1'b0);
        $display("test enable done");
        // Clock enable low freezes lines, steps and ready
        ce = 1'b0;
        i_sdsi_ctrl_model.pulse(2'b01);
        i_sdsi_ctrl_model.set_enable(1'b0);
        repeat (4) @(negedge clk_sys);
        cmp_bit("amp_frozen", 1'b1, amp_en);
        cmp_bit("ready_frozen", 1'b0, ready_n);
        cmp_pos(pos_exp, position);
        ce = 1'b1;
        repeat (4) @(negedge clk_sys);
        cmp_bit("amp_enable", 1'b0, amp_en);
        wait_ready(1'b1);
        $display("test freeze done");
        for (int k = 0; k < 4; k++)
        begin
            meaning = sdsi_stat_type'(k[0]);
            fault = 1'($random(seed));
            speed = 1'($random(seed));
            repeat (3) @(negedge clk_sys);
            w = (meaning == SDSI_STAT_ERROR) ? fault : speed;
            cmp_bit("status", w, stat);
            cmp_bit("status_n", ~w, stat_n);
        end
        $display("test status done");
        cmp_bit("notes_left", 1'b0, exp_q.size() != 0);
        test_done();
    end
endmodule

`default_nettype wire
